// ===== usd_pkg.sv
/*
 * shared constants of the shadow data port: register map, fields,
 * serial timing and state encodings.
 * assumes one 50 MHz clock and a 32-bit AXI4-Lite register bus.
 */
package usd_pkg;
	localparam int unsigned CHAR_W         = 8;
	localparam int unsigned FIFO_DEPTH     = 16;
	localparam int unsigned CLKS_PER_BIT   = 16;
	localparam int unsigned IR_PULSE_NUM   = 3;
	localparam int unsigned IR_PULSE_DEN   = 16;
	localparam logic [31:0] SLOT_A_ADDR    = 32'h5000113c;
	localparam logic [31:0] SLOT_B_ADDR    = 32'h50001140;
	localparam logic [31:0] CTRL_ADDR      = 32'h50001150;
	localparam logic [31:0] LINE_STAT_ADDR = 32'h50001154;
	localparam logic [31:0] INT_STAT_ADDR  = 32'h50001158;
	localparam logic [31:0] INT_MASK_ADDR  = 32'h5000115c;
	localparam int unsigned CTRL_FIFO_EN   = 0;
	localparam int unsigned CTRL_IR_MODE   = 1;
	localparam int unsigned LS_DATA_READY  = 0;
	localparam int unsigned LS_OVERRUN     = 1;
	localparam int unsigned LS_TX_EMPTY    = 5;
	localparam int unsigned EV_RX          = 0;
	localparam int unsigned EV_OVR         = 1;
	localparam int unsigned EV_TX_EMPTY    = 2;
	localparam int unsigned EV_W           = 3;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	localparam logic [1:0]  CTRL_RESET     = 2'h0;

	typedef enum logic [1:0] {
		SER_IDLE,
		SER_START,
		SER_DATA,
		SER_STOP
	} usd_ser_e;
endpackage

// ===== usd_fifo_if.sv
/*
 * carrier between the port logic and its character fifos.
 * assumes the store side keeps contents unchanged on a refused push.
 */
`timescale 1ns/100ps
`default_nettype none
interface usd_fifo_if #(
	parameter int unsigned W = 8
) ();
	logic         push;
	logic [W-1:0] wdata;
	logic         full;
	logic         pop;
	logic [W-1:0] rdata;
	logic         empty;
	logic         flush;

	modport store (input push, input wdata, input pop, input flush,
		output full, output rdata, output empty);
	modport user (output push, output wdata, output pop, output flush,
		input full, input rdata, input empty);
endinterface
`default_nettype wire

// ===== usd_fifo.sv
/*
 * flip-flop character fifo, depth and width as parameters.
 * assumes the user pops only when not empty; a push when full is dropped.
 */
`timescale 1ns/100ps
`default_nettype none
module usd_fifo #(
	parameter int unsigned W = 8,
	parameter int unsigned D = 16
) (
	input  wire logic   aclk,
	input  wire logic   aresetn,
	usd_fifo_if.store   f
);
	localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
	localparam int unsigned CW = $clog2(D + 1);

	logic [W-1:0]  mem_q [D];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic          do_push;
	logic          do_pop;

	// full blocks the push even with a pop in the same cycle
	assign do_push = f.push && !f.full;
	assign do_pop  = f.pop && !f.empty;
	assign f.full  = (cnt_q == CW'(D));
	assign f.empty = (cnt_q == '0);
	assign f.rdata = mem_q[rd_q];

	always_ff @(posedge aclk) begin
		if (do_push) begin
			mem_q[wr_q] <= f.wdata;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || f.flush) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (do_push) begin
				wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
			end
			if (do_pop) begin
				rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
		end
	end
endmodule
`default_nettype wire

// ===== usd_port.sv
/*
 * serial port data path behind aliased shadow data slots, with
 * receiver, transmitter, line status, interrupts and an AXI4-Lite slave.
 * assumes line inputs synchronous to aclk and one master on the bus.
 */
`timescale 1ns/100ps
`default_nettype none
module usd_port #(
	parameter int unsigned FIFO_DEPTH   = usd_pkg::FIFO_DEPTH,
	parameter int unsigned CLKS_PER_BIT = usd_pkg::CLKS_PER_BIT
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [31:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        serial_rx,
	input  wire logic        ir_rx,
	output logic             serial_tx,
	output logic             ir_tx_n,
	output logic             irq
);
	localparam int unsigned W  = usd_pkg::CHAR_W;
	localparam int unsigned CW = $clog2(CLKS_PER_BIT + 1);
	localparam int unsigned IR_CLKS =
		(CLKS_PER_BIT * usd_pkg::IR_PULSE_NUM) / usd_pkg::IR_PULSE_DEN;
	localparam logic [CW-1:0] BIT_LAST = CW'(CLKS_PER_BIT - 1);
	localparam logic [CW-1:0] BIT_HALF = CW'(CLKS_PER_BIT / 2);
	localparam logic [CW-1:0] IR_LEN   = CW'((IR_CLKS > 0) ? IR_CLKS : 1);

	function automatic logic is_slot(input logic [31:0] a);
		return (a == usd_pkg::SLOT_A_ADDR) || (a == usd_pkg::SLOT_B_ADDR);
	endfunction

	function automatic logic is_mapped(input logic [31:0] a);
		return is_slot(a) || (a == usd_pkg::CTRL_ADDR) ||
			(a == usd_pkg::LINE_STAT_ADDR) || (a == usd_pkg::INT_STAT_ADDR) ||
			(a == usd_pkg::INT_MASK_ADDR);
	endfunction

	usd_fifo_if #(.W(W)) rxf ();
	usd_fifo_if #(.W(W)) txf ();

	usd_fifo #(.W(W), .D(FIFO_DEPTH)) u_rx_fifo (
		.aclk    (aclk),
		.aresetn (aresetn),
		.f       (rxf)
	);
	usd_fifo #(.W(W), .D(FIFO_DEPTH)) u_tx_fifo (
		.aclk    (aclk),
		.aresetn (aresetn),
		.f       (txf)
	);

	logic [31:0]          aw_addr_q;
	logic [31:0]          w_data_q;
	logic [3:0]           w_strb_q;
	logic                 aw_have_q;
	logic                 w_have_q;
	logic                 wr_fire;
	logic                 wr_slot;
	logic                 ar_hs;
	logic                 rd_pop;
	logic [1:0]           ctrl_q;
	logic                 fifo_en;
	logic                 ir_mode;
	logic                 mode_chg;
	logic [usd_pkg::EV_W-1:0] int_stat_q;
	logic [usd_pkg::EV_W-1:0] int_mask_q;
	logic [usd_pkg::EV_W-1:0] ev;
	logic [usd_pkg::EV_W-1:0] clr;
	logic                 rx_hold_valid_q;
	logic [W-1:0]         rx_hold_q;
	logic                 data_ready;
	logic                 overrun;
	logic                 tx_hold_full_q;
	logic [W-1:0]         tx_hold_q;
	logic                 tx_empty;
	logic                 tx_empty_prev_q;
	logic                 tx_go;
	logic [31:0]          rd_word;

	assign fifo_en = ctrl_q[usd_pkg::CTRL_FIFO_EN];
	assign ir_mode = ctrl_q[usd_pkg::CTRL_IR_MODE];

	////////////////////////////////////////////////////////////////////
	// write channels: address and data taken in either order

	assign wr_fire  = aw_have_q && w_have_q && !bvalid;
	assign wr_slot  = wr_fire && is_slot(aw_addr_q) && w_strb_q[0];
	assign mode_chg = wr_fire && (aw_addr_q == usd_pkg::CTRL_ADDR) && w_strb_q[0] &&
		(w_data_q[usd_pkg::CTRL_FIFO_EN] != fifo_en);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready   <= 1'b1;
			wready    <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
			bvalid    <= 1'b0;
			bresp     <= usd_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_addr_q <= awaddr;
				aw_have_q <= 1'b1;
				awready   <= 1'b0;
			end
			if (wvalid && wready) begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
				w_have_q <= 1'b1;
				wready   <= 1'b0;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid    <= 1'b1;
				bresp     <= is_mapped(aw_addr_q) ? usd_pkg::RESP_OKAY
					: usd_pkg::RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q     <= usd_pkg::CTRL_RESET;
			int_mask_q <= '0;
		end else if (wr_fire && w_strb_q[0]) begin
			if (aw_addr_q == usd_pkg::CTRL_ADDR) begin
				ctrl_q <= w_data_q[1:0];
			end
			if (aw_addr_q == usd_pkg::INT_MASK_ADDR) begin
				int_mask_q <= w_data_q[usd_pkg::EV_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// read channel; a slot read consumes the received character

	assign ar_hs  = arvalid && arready;
	assign rd_pop = ar_hs && is_slot(araddr);

	always_comb begin
		rd_word = '0;
		if (is_slot(araddr)) begin
			rd_word[W-1:0] = fifo_en ? rxf.rdata : rx_hold_q;
		end else if (araddr == usd_pkg::CTRL_ADDR) begin
			rd_word[1:0] = ctrl_q;
		end else if (araddr == usd_pkg::LINE_STAT_ADDR) begin
			rd_word[usd_pkg::LS_DATA_READY] = data_ready;
			rd_word[usd_pkg::LS_OVERRUN]    = int_stat_q[usd_pkg::EV_OVR];
			rd_word[usd_pkg::LS_TX_EMPTY]   = tx_empty;
		end else if (araddr == usd_pkg::INT_STAT_ADDR) begin
			rd_word[usd_pkg::EV_W-1:0] = int_stat_q;
		end else if (araddr == usd_pkg::INT_MASK_ADDR) begin
			rd_word[usd_pkg::EV_W-1:0] = int_mask_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= usd_pkg::RESP_OKAY;
		end else begin
			if (ar_hs) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= rd_word;
				rresp   <= is_mapped(araddr) ? usd_pkg::RESP_OKAY
					: usd_pkg::RESP_SLVERR;
			end
			if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// receiver

	usd_pkg::usd_ser_e rx_st_q;
	logic [CW-1:0]     rx_cnt_q;
	logic [2:0]        rx_bit_q;
	logic [W-1:0]      rx_sh_q;
	logic              rx_done_q;
	logic              rx_line;

	// ir input pulses high for a zero bit, stretched outside this block
	assign rx_line = ir_mode ? !ir_rx : serial_rx;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_st_q   <= usd_pkg::SER_IDLE;
			rx_cnt_q  <= '0;
			rx_bit_q  <= '0;
			rx_sh_q   <= '0;
			rx_done_q <= 1'b0;
		end else begin
			rx_done_q <= 1'b0;
			rx_cnt_q  <= rx_cnt_q + 1'b1;
			case (rx_st_q)
				usd_pkg::SER_IDLE: begin
					rx_cnt_q <= '0;
					if (!rx_line) begin
						rx_st_q <= usd_pkg::SER_START;
					end
				end
				usd_pkg::SER_START: begin
					if (rx_cnt_q == BIT_HALF) begin
						rx_cnt_q <= '0;
						rx_bit_q <= '0;
						rx_st_q  <= rx_line ? usd_pkg::SER_IDLE : usd_pkg::SER_DATA;
					end
				end
				usd_pkg::SER_DATA: begin
					if (rx_cnt_q == BIT_LAST) begin
						rx_cnt_q <= '0;
						rx_sh_q  <= {rx_line, rx_sh_q[W-1:1]};
						rx_bit_q <= rx_bit_q + 1'b1;
						if (rx_bit_q == 3'h7) begin
							rx_st_q <= usd_pkg::SER_STOP;
						end
					end
				end
				usd_pkg::SER_STOP: begin
					if (rx_cnt_q == BIT_LAST) begin
						rx_done_q <= 1'b1;
						rx_st_q   <= usd_pkg::SER_IDLE;
					end
				end
				default: rx_st_q <= usd_pkg::SER_IDLE;
			endcase
		end
	end

	assign rxf.push  = rx_done_q && fifo_en;
	assign rxf.wdata = rx_sh_q;
	assign rxf.pop   = rd_pop && fifo_en;
	assign rxf.flush = mode_chg;
	assign data_ready = fifo_en ? !rxf.empty : rx_hold_valid_q;
	assign overrun = rx_done_q && (fifo_en ? rxf.full
		: (rx_hold_valid_q && !rd_pop));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_hold_valid_q <= 1'b0;
			rx_hold_q       <= '0;
		end else begin
			if (rd_pop || fifo_en) begin
				rx_hold_valid_q <= 1'b0;
			end
			if (rx_done_q && !fifo_en) begin
				rx_hold_q       <= rx_sh_q;
				rx_hold_valid_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// transmit holding and transmitter

	usd_pkg::usd_ser_e tx_st_q;
	logic [CW-1:0]     tx_cnt_q;
	logic [2:0]        tx_bit_q;
	logic [W-1:0]      tx_sh_q;
	logic              tx_level;

	assign tx_empty  = fifo_en ? txf.empty : !tx_hold_full_q;
	assign tx_go     = (tx_st_q == usd_pkg::SER_IDLE) && !tx_empty;
	assign txf.push  = wr_slot && fifo_en;
	assign txf.wdata = w_data_q[W-1:0];
	assign txf.pop   = tx_go && fifo_en;
	assign txf.flush = mode_chg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_hold_full_q <= 1'b0;
			tx_hold_q      <= '0;
		end else begin
			if ((tx_go && !fifo_en) || fifo_en) begin
				tx_hold_full_q <= 1'b0;
			end
			// a write wins over the transmitter taking the old byte
			if (wr_slot && !fifo_en) begin
				tx_hold_q      <= w_data_q[W-1:0];
				tx_hold_full_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_st_q  <= usd_pkg::SER_IDLE;
			tx_cnt_q <= '0;
			tx_bit_q <= '0;
			tx_sh_q  <= '0;
		end else begin
			tx_cnt_q <= tx_cnt_q + 1'b1;
			case (tx_st_q)
				usd_pkg::SER_IDLE: begin
					tx_cnt_q <= '0;
					if (tx_go) begin
						tx_sh_q <= fifo_en ? txf.rdata : tx_hold_q;
						tx_st_q <= usd_pkg::SER_START;
					end
				end
				usd_pkg::SER_START: begin
					if (tx_cnt_q == BIT_LAST) begin
						tx_cnt_q <= '0;
						tx_bit_q <= '0;
						tx_st_q  <= usd_pkg::SER_DATA;
					end
				end
				usd_pkg::SER_DATA: begin
					if (tx_cnt_q == BIT_LAST) begin
						tx_cnt_q <= '0;
						tx_sh_q  <= {1'b1, tx_sh_q[W-1:1]};
						tx_bit_q <= tx_bit_q + 1'b1;
						if (tx_bit_q == 3'h7) begin
							tx_st_q <= usd_pkg::SER_STOP;
						end
					end
				end
				usd_pkg::SER_STOP: begin
					if (tx_cnt_q == BIT_LAST) begin
						tx_st_q <= usd_pkg::SER_IDLE;
					end
				end
				default: tx_st_q <= usd_pkg::SER_IDLE;
			endcase
		end
	end

	always_comb begin
		case (tx_st_q)
			usd_pkg::SER_START: tx_level = 1'b0;
			usd_pkg::SER_DATA:  tx_level = tx_sh_q[0];
			default:            tx_level = 1'b1;
		endcase
	end

	// ir sends a short low pulse per zero bit; serial line then idles high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_tx <= 1'b1;
			ir_tx_n   <= 1'b1;
		end else begin
			serial_tx <= ir_mode ? 1'b1 : tx_level;
			ir_tx_n   <= !(ir_mode && !tx_level && (tx_cnt_q < IR_LEN));
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupts: sticky status, write one to clear, set wins

	assign ev[usd_pkg::EV_RX]       = rx_done_q;
	assign ev[usd_pkg::EV_OVR]      = overrun;
	assign ev[usd_pkg::EV_TX_EMPTY] = tx_empty && !tx_empty_prev_q;
	assign clr = (wr_fire && w_strb_q[0] && (aw_addr_q == usd_pkg::INT_STAT_ADDR))
		? w_data_q[usd_pkg::EV_W-1:0] : '0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_stat_q      <= '0;
			tx_empty_prev_q <= 1'b1;
			irq             <= 1'b0;
		end else begin
			int_stat_q      <= (int_stat_q & ~clr) | ev;
			tx_empty_prev_q <= tx_empty;
			irq             <= |(((int_stat_q & ~clr) | ev) & int_mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_slot_write_plain;
		wr_slot && !fifo_en && !tx_go;
	endsequence
	sequence s_rx_collide;
		rx_done_q && !fifo_en && rx_hold_valid_q && !rd_pop;
	endsequence

	AST_SLOT_REPLACE: assert property (
		s_slot_write_plain |=> tx_hold_q == $past(w_data_q[W-1:0]) && !tx_empty)
		else $error("pending transmit byte not replaced");
	AST_EMPTY_CLEAR: assert property (
		wr_slot && !fifo_en && !mode_chg |=> !tx_empty)
		else $error("tx holding empty flag not cleared");
	AST_NOFIFO_OVERRUN: assert property (
		s_rx_collide |=> int_stat_q[usd_pkg::EV_OVR] && rx_hold_q == $past(rx_sh_q))
		else $error("overwrite without overrun");
	AST_FULL_KEEP: assert property (
		rx_done_q && fifo_en && rxf.full && !rxf.pop && !mode_chg
		|=> rxf.full && int_stat_q[usd_pkg::EV_OVR])
		else $error("full receive fifo changed or no overrun");
	AST_HEAD_READ: assert property (
		rd_pop && fifo_en && !rxf.empty |=> rvalid && rdata[W-1:0] == $past(rxf.rdata))
		else $error("slot read is not the fifo head");
	AST_RESERVED_ZERO: assert property (
		rd_pop ##1 rvalid |-> rdata[31:W] == '0)
		else $error("reserved slot bits not zero");
	AST_TX_DROP: assert property (
		wr_slot && fifo_en && txf.full && !txf.pop && !mode_chg |=> txf.full)
		else $error("write to full tx fifo not dropped");
	AST_IR_SERIAL_IDLE: assert property (
		ir_mode && $past(ir_mode) |-> serial_tx)
		else $error("serial output active in ir mode");
	AST_START_BIT: assert property (
		tx_go && !ir_mode && !mode_chg ##1 !ir_mode |=> !serial_tx)
		else $error("no start bit after load");
	AST_B_HOLD: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
endmodule
`default_nettype wire

// ===== usd_peer.sv
/*
 * remote serial peer: frames characters onto the port's receive line and
 * collects the characters the port transmits.
 * assumes its bit period in aclk cycles equals the port's setting.
 */
`timescale 1ns/100ps
`default_nettype none
module usd_peer #(
	parameter int unsigned CPB = 16
) (
	input  wire logic aclk,
	input  wire logic line_in,
	output var logic  line_out,
	output var logic  ir_out
);
	logic [7:0] rx_q[$];

	initial line_out = 1'b1;
	// ir line is active high: high for a zero bit, low when idle
	initial ir_out = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// start low, eight bits lsb first, stop high; line idles high between
	task automatic send(input logic [7:0] b, input bit ir = 1'b0);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge aclk);
			if (ir) begin
				ir_out <= !fr[i];
			end else begin
				line_out <= fr[i];
			end
			repeat (CPB - 1) @(posedge aclk);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// mid-bit sampling, so the port's one-clock output lag does not matter
	always begin
		logic [7:0] b;
		@(negedge line_in);
		repeat (CPB / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			repeat (CPB) @(posedge aclk);
			b[i] = line_in;
		end
		repeat (CPB) @(posedge aclk);
		rx_q.push_back(b);
	end
endmodule
`default_nettype wire

// ===== testbench.sv
/*
 * self-checking bench of the shadow data port: bus tasks and scenarios.
 * assumes the port, its fifo and the serial peer model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam int unsigned CPB = 16;
	localparam int unsigned IRL = CPB * usd_pkg::IR_PULSE_NUM / usd_pkg::IR_PULSE_DEN;
	localparam logic [31:0] SA  = usd_pkg::SLOT_A_ADDR;
	localparam logic [31:0] SB  = usd_pkg::SLOT_B_ADDR;
	localparam logic [31:0] CT  = usd_pkg::CTRL_ADDR;
	localparam logic [31:0] LS  = usd_pkg::LINE_STAT_ADDR;
	localparam logic [31:0] IS  = usd_pkg::INT_STAT_ADDR;
	localparam logic [31:0] IM  = usd_pkg::INT_MASK_ADDR;
	localparam logic [1:0]  OK  = usd_pkg::RESP_OKAY;
	localparam logic [1:0]  ER  = usd_pkg::RESP_SLVERR;
	logic        aclk, aresetn;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [1:0]  bresp, rresp;
	logic [3:0]  wstrb;
	logic        serial_rx, ir_rx, serial_tx, ir_tx_n, irq;
	int          n_fail, samples_checked, c_ir, c_ser;

	usd_port #(.FIFO_DEPTH(2), .CLKS_PER_BIT(CPB)) usd_port_i (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .serial_rx(serial_rx),
		.ir_rx(ir_rx), .serial_tx(serial_tx), .ir_tx_n(ir_tx_n), .irq(irq)
	);
	usd_peer #(.CPB(CPB)) usd_peer_i (
		.aclk(aclk), .line_in(serial_tx), .line_out(serial_rx), .ir_out(ir_rx)
	);

	always #10 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// every polling loop waits through here so no loop can hang the run
	task automatic tick(inout int n);
		@(posedge aclk);
		n++;
		if (n > 3000) begin
			n_fail++;
			$display("wrong value wait bound expected done seen timeout");
			report_and_stop();
		end
	endtask

	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		bit ad, wd;
		n = 0;
		ad = 0;
		wd = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			tick(n);
			if (!ad && awready) begin
				ad = 1;
				awvalid <= 1'b0;
			end
			if (!wd && wready) begin
				wd = 1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) tick(n);
		bready <= 1'b0;
		check("bresp", {30'h0, er}, {30'h0, bresp});
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do tick(n); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) tick(n);
		rready <= 1'b0;
		check("rdata", e, rdata);
		check("rresp", {30'h0, er}, {30'h0, rresp});
	endtask

	task automatic wait_rx(input int k);
		int n;
		n = 0;
		while (usd_peer_i.rx_q.size() < k) tick(n);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awaddr, wdata, araddr} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hf;
		n_fail = 0;
		samples_checked = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CT, 32'h0, OK);
		rd(LS, 32'h20, OK);
		rd(32'h50001160, 32'h0, ER);
		wr(32'h50001160, 32'h1, ER);
		// a write without the low byte lane must leave the mask alone
		wstrb <= 4'he;
		wr(IM, 32'h7, OK);
		wstrb <= 4'hf;
		rd(IM, 32'h0, OK);
		$display("test reset values ended");
		// masked event must stay off the interrupt line
		usd_peer_i.send(8'ha5);
		repeat (4) @(posedge aclk);
		check("irq masked", 32'h0, {31'h0, irq});
		rd(IS, 32'h1, OK);
		wr(IM, 32'h1, OK);
		repeat (2) @(posedge aclk);
		check("irq unmasked", 32'h1, {31'h0, irq});
		rd(LS, 32'h21, OK);
		rd(SA, 32'ha5, OK);
		wr(IS, 32'h1, OK);
		repeat (2) @(posedge aclk);
		check("irq cleared", 32'h0, {31'h0, irq});
		rd(IS, 32'h0, OK);
		$display("test receive and interrupt ended");
		usd_peer_i.rx_q.delete();
		rd(LS, 32'h20, OK);
		wr(SB, 32'hffffff01, OK);
		wr(SA, 32'h02, OK);
		rd(LS, 32'h00, OK);
		wr(SB, 32'h03, OK);
		wait_rx(2);
		check("tx char 0", 32'h01, {24'h0, usd_peer_i.rx_q[0]});
		check("tx char 1", 32'h03, {24'h0, usd_peer_i.rx_q[1]});
		repeat (CPB * 12) @(posedge aclk);
		check("tx count", 32'h2, usd_peer_i.rx_q.size());
		$display("test transmit without fifo ended");
		usd_peer_i.send(8'h11);
		usd_peer_i.send(8'h22);
		repeat (4) @(posedge aclk);
		rd(LS, 32'h23, OK);
		rd(SB, 32'h22, OK);
		wr(IS, 32'h7, OK);
		rd(LS, 32'h20, OK);
		$display("test overrun without fifo ended");
		wr(CT, 32'h1, OK);
		usd_peer_i.send(8'h31);
		usd_peer_i.send(8'h32);
		usd_peer_i.send(8'h33);
		repeat (4) @(posedge aclk);
		rd(LS, 32'h23, OK);
		rd(SA, 32'h31, OK);
		rd(SB, 32'h32, OK);
		rd(LS, 32'h22, OK);
		usd_peer_i.rx_q.delete();
		// one goes straight to the shifter, two fill the fifo, the rest drop
		for (int i = 0; i < 5; i++) wr(SA, 32'h41 + i, OK);
		wait_rx(3);
		for (int i = 0; i < 3; i++) check("fifo tx", 32'h41 + i, usd_peer_i.rx_q[i]);
		repeat (CPB * 12) @(posedge aclk);
		check("fifo tx count", 32'h3, usd_peer_i.rx_q.size());
		$display("test fifo mode ended");
		wr(CT, 32'h2, OK);
		wr(SA, 32'h00, OK);
		c_ir = 0;
		c_ser = 0;
		repeat (CPB * 11) begin
			@(posedge aclk);
			if (ir_tx_n === 1'b0) c_ir++;
			if (serial_tx !== 1'b1) c_ser++;
		end
		check("ir low clocks", 9 * IRL, c_ir);
		check("serial low clocks", 32'h0, c_ser);
		usd_peer_i.send(8'h5c, 1'b1);
		repeat (4) @(posedge aclk);
		rd(SA, 32'h5c, OK);
		$display("test infrared ended");
		report_and_stop();
	end
endmodule
`default_nettype wire
